/* File: include/vector_place_pkg.sv */
// Constants for the interrupt vector placement block.
// Assumes a CPU that reports its program counter and instruction ends.
package vector_place_pkg;

    // ========================================
    // Register map
    localparam logic [7:0] CTRL_ADDR = 8'h35;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int CHANGE_ENABLE_BIT = 0;
    localparam int SELECT_BIT = 1;

    // ========================================
    // Timing
    localparam int UNLOCK_CYCLES = 4;
    localparam logic [2:0] UNLOCK_LAST = 3'(UNLOCK_CYCLES - 1);

    // ========================================
    // Flash layout, word addresses
    localparam int PC_W = 13;
    localparam logic [12:0] APP_BASE = 13'h0000;
    localparam logic [12:0] BOOT_START_00 = 13'h1c00;
    localparam logic [12:0] BOOT_START_01 = 13'h1e00;
    localparam logic [12:0] BOOT_START_10 = 13'h1f00;
    localparam logic [12:0] BOOT_START_11 = 13'h1f80;
    localparam int VECTOR_IDX_W = 5;

    // ========================================
    // Unlock sequencer
    typedef enum logic [1:0] {
        UNLOCK_IDLE = 2'b00,
        UNLOCK_ARMED = 2'b01,
        UNLOCK_HOLD = 2'b10
    } unlock_state_t;

    typedef struct packed {
        unlock_state_t state;
        logic [2:0] cnt;
        logic vsel;
        logic [7:0] rdata;
        logic block;
        logic suppress;
        logic irq_ok;
        logic [12:0] vbase;
        logic [12:0] vaddr;
        logic [12:0] raddr;
    } place_state_t;

endpackage

/* File: verilog/interrupt_vector_placement.sv */
// Interrupt vector placement control with timed unlock.
// Assumes synchronous CPU-side inputs and a one-cycle register port.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

module interrupt_vector_placement
    import vector_place_pkg::*;
#(
    parameter logic [12:0] BOOT_START_SZ0 = BOOT_START_00,
    parameter logic [12:0] BOOT_START_SZ1 = BOOT_START_01,
    parameter logic [12:0] BOOT_START_SZ2 = BOOT_START_10,
    parameter logic [12:0] BOOT_START_SZ3 = BOOT_START_11
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Fuses and lock bits, high means programmed
    input wire logic [1:0] boot_size_fuses,
    input wire logic boot_reset_fuse,
    input wire logic app_boot_lock_bit,
    input wire logic boot_boot_lock_bit,
    // CPU side
    input wire logic [12:0] cpu_pc,
    input wire logic instr_end,
    input wire logic global_irq_enable,
    input wire logic [4:0] vector_index,
    // Placement results
    output logic irq_block,
    output logic lock_suppress,
    output logic irq_allowed,
    output logic [12:0] vector_base,
    output logic [12:0] vector_addr,
    output logic [12:0] reset_addr
);

    // ========================================
    // Elaboration checks
    // Slot spacing of two words needs the boot start word aligned
    if (BOOT_START_SZ0[0] || BOOT_START_SZ1[0] ||
        BOOT_START_SZ2[0] || BOOT_START_SZ3[0])
    begin : g_bad_start
        $error("boot start must be an even word address");
    end

    // Window counter is three bits wide
    if (UNLOCK_CYCLES < 1 || UNLOCK_CYCLES > 8)
    begin : g_bad_window
        $error("unlock window must be 1 to 8 cycles");
    end

    place_state_t s;
    place_state_t next_s;
    logic hit_wr;
    logic hit_rd;
    logic armed;
    logic [12:0] boot_start;
    logic in_boot;

    // ========================================
    // Decode
    // Only the exact control address may touch the unlock state
    assign hit_wr = wr && (addr == CTRL_ADDR);
    assign hit_rd = rd && (addr == CTRL_ADDR);
    assign armed = (s.state == UNLOCK_ARMED);

    always_comb
    begin
        case (boot_size_fuses)
            2'b00: boot_start = BOOT_START_SZ0;
            2'b01: boot_start = BOOT_START_SZ1;
            2'b10: boot_start = BOOT_START_SZ2;
            2'b11: boot_start = BOOT_START_SZ3;
            default: boot_start = BOOT_START_SZ0;
        endcase
    end

    // Boot section runs from its start word to the top of flash
    assign in_boot = (cpu_pc >= boot_start);

    // ========================================
    // Next state
    always_comb
    begin
        next_s = s;
        next_s.rdata = 8'h00;
        if (hit_rd)
        begin
            next_s.rdata[SELECT_BIT] = s.vsel;
            next_s.rdata[CHANGE_ENABLE_BIT] = armed;
        end
        case (s.state)
            UNLOCK_IDLE:
            begin
                if (hit_wr && wdata[CHANGE_ENABLE_BIT])
                begin
                    next_s.state = UNLOCK_ARMED;
                    next_s.cnt = UNLOCK_LAST;
                end
            end
            UNLOCK_ARMED:
            begin
                if (hit_wr && wdata[CHANGE_ENABLE_BIT])
                begin
                    next_s.cnt = UNLOCK_LAST;
                end
                else if (hit_wr)
                begin
                    next_s.vsel = wdata[SELECT_BIT];
                    next_s.state = UNLOCK_HOLD;
                end
                else if (s.cnt == 3'h0)
                begin
                    next_s.state = UNLOCK_IDLE;
                end
                else
                begin
                    next_s.cnt = s.cnt - 3'h1;
                end
            end
            UNLOCK_HOLD:
            begin
                // No instruction end keeps the block up indefinitely
                // release after next instruction
                if (instr_end)
                begin
                    next_s.state = UNLOCK_IDLE;
                end
            end
            default:
            begin
                next_s.state = UNLOCK_IDLE;
            end
        endcase
        next_s.block = (next_s.state != UNLOCK_IDLE);
        next_s.suppress = (next_s.vsel && app_boot_lock_bit && !in_boot) ||
            (!next_s.vsel && boot_boot_lock_bit && in_boot);
        // global enable only gated, never written
        next_s.irq_ok = global_irq_enable && !next_s.block &&
            !next_s.suppress;
        next_s.vbase = next_s.vsel ? boot_start : APP_BASE;
        next_s.vaddr = next_s.vbase + {7'h00, vector_index, 1'b0};
        next_s.raddr = boot_reset_fuse ? boot_start : APP_BASE;
    end

    // ========================================
    // State register
    // cleared by reset
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign rdata = s.rdata;
    assign irq_block = s.block;
    assign lock_suppress = s.suppress;
    assign irq_allowed = s.irq_ok;
    assign vector_base = s.vbase;
    assign vector_addr = s.vaddr;
    assign reset_addr = s.raddr;

    // ========================================
    // Assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // Reset outputs are constants, so checks start after release

    a_arm_blocks: assert property (
        s.state == UNLOCK_IDLE && hit_wr && wdata[0] |=>
        irq_block && armed)
    else $error("arming did not block interrupts");

    a_block_four: assert property (
        $rose(armed) ##0 (!hit_wr) [*4] |->
        irq_block && $past(irq_block, 3))
    else $error("block shorter than four cycles");

    a_window_expiry: assert property (
        $rose(armed) ##0 (!hit_wr) [*4] |=> !armed && !irq_block)
    else $error("change enable not cleared after four cycles");

    a_select_taken: assert property (
        armed && hit_wr && !wdata[0] |=>
        s.vsel == $past(wdata[1]) && !armed)
    else $error("select write inside window not taken");

    a_select_locked: assert property (
        !armed && hit_wr |=> $stable(s.vsel))
    else $error("select changed without unlock");

    a_hold_release: assert property (
        s.state == UNLOCK_HOLD && instr_end |=> !irq_block)
    else $error("block not released after instruction");

    a_gie_gate: assert property (
        ##1 irq_allowed == ($past(global_irq_enable) && !irq_block &&
        !lock_suppress))
    else $error("interrupt permission not gated by global enable");

    a_app_suppress: assert property (
        next_s.vsel && app_boot_lock_bit && !in_boot |=> lock_suppress)
    else $error("application code not suppressed");

    a_boot_suppress: assert property (
        !next_s.vsel && boot_boot_lock_bit && in_boot |=> lock_suppress)
    else $error("boot code not suppressed");

    a_base_track: assert property (
        ##1 vector_addr == vector_base + {7'h00, $past(vector_index), 1'b0})
    else $error("vector address not base plus slot");

    a_reset_start: assert property (
        boot_reset_fuse |=> reset_addr == $past(boot_start))
    else $error("reset address not at boot start");

    a_read_back: assert property (
        hit_rd |=> rdata[7:2] == 6'h00 && rdata[1] == s.vsel)
    else $error("control read wrong");

    c_move_vectors: cover property (
        armed && hit_wr && !wdata[0] && wdata[1]);
    c_window_lapse: cover property (
        armed && s.cnt == 3'h0 && !hit_wr);
    c_lock_hit: cover property (lock_suppress && global_irq_enable);

    a_read_armed: assert property (
        hit_rd |=> rdata[CHANGE_ENABLE_BIT] == $past(armed))
    else $error("change enable read back wrong");

    a_read_idle: assert property (
        !hit_rd |=> rdata == 8'h00)
    else $error("read data not cleared outside read");

    a_rearm_restart: assert property (
        armed && hit_wr && wdata[CHANGE_ENABLE_BIT] |=>
        armed && s.cnt == UNLOCK_LAST && $stable(s.vsel))
    else $error("rearm did not restart window");

    a_hold_waits: assert property (
        s.state == UNLOCK_HOLD && !instr_end |=>
        irq_block && s.state == UNLOCK_HOLD)
    else $error("block dropped before instruction end");

    a_idle_unblocked: assert property (
        s.state == UNLOCK_IDLE && !(hit_wr && wdata[CHANGE_ENABLE_BIT])
        |=> !irq_block)
    else $error("block raised without arming");

    a_no_arm_unmapped: assert property (
        wr && addr != CTRL_ADDR && s.state == UNLOCK_IDLE |=> !armed)
    else $error("unmapped write armed the unlock");

    a_base_select: assert property (
        ##1 vector_base == (s.vsel ? $past(boot_start) : APP_BASE))
    else $error("vector base does not follow select");

    a_reset_app: assert property (
        !boot_reset_fuse |=> reset_addr == APP_BASE)
    else $error("reset address not at flash start");

    a_allowed_blocked: assert property (
        irq_block || lock_suppress |-> !irq_allowed)
    else $error("interrupts allowed while blocked");

    a_suppress_clear: assert property (
        !app_boot_lock_bit && !boot_boot_lock_bit |=> !lock_suppress)
    else $error("suppress without a lock bit");

    c_rearm: cover property (armed && hit_wr && wdata[CHANGE_ENABLE_BIT]);
    c_hold_release: cover property (s.state == UNLOCK_HOLD && instr_end);

endmodule

`default_nettype wire

/* File: verif/interrupt_vector_placement_tb.sv */
// Self-checking bench for the interrupt vector placement block.
// Assumes the design package is compiled first and one 250 MHz clock.
`timescale 1ns/10ps
`default_nettype none

module interrupt_vector_placement_tb
    import vector_place_pkg::*;
;
    // ========================================
    // Stimulus and observed signals
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [1:0] fuses = 2'h0;
    logic brf = 1'b0;
    logic alock = 1'b0;
    logic block_bit = 1'b0;
    logic gie = 1'b0;
    logic iend = 1'b0;
    logic [12:0] pc = 13'h0000;
    logic [4:0] idx = 5'h00;
    logic [7:0] rdata;
    logic blk, supp, allow;
    logic [12:0] base, vaddr, raddr;
    logic [31:0] seed = 32'h000154bf;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #2 clk = ~clk;

    interrupt_vector_placement i_dut (.clk(clk), .reset(reset),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .boot_size_fuses(fuses), .boot_reset_fuse(brf),
        .app_boot_lock_bit(alock), .boot_boot_lock_bit(block_bit),
        .cpu_pc(pc), .instr_end(iend), .global_irq_enable(gie),
        .vector_index(idx), .irq_block(blk), .lock_suppress(supp),
        .irq_allowed(allow), .vector_base(base), .vector_addr(vaddr),
        .reset_addr(raddr));

    // ========================================
    // Helpers
    function automatic logic [31:0] rand32();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [12:0] boot_start(input logic [1:0] f);
        case (f)
            2'h0: return BOOT_START_00;
            2'h1: return BOOT_START_01;
            2'h2: return BOOT_START_10;
            default: return BOOT_START_11;
        endcase
    endfunction

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [12:0] exp,
                       input logic [12:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic bus_rd(input logic [7:0] a, input logic [7:0] e,
                          input string what);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(what, {5'h00, e}, {5'h00, rdata});
    endtask

    task automatic end_instr();
        @(posedge clk);
        iend <= 1'b1;
        @(posedge clk);
        iend <= 1'b0;
        tick(1);
    endtask

    // Random fuses, locks and pc, with pc often on the boot boundary
    task automatic sweep(input logic vsel);
        logic [31:0] r;
        logic [12:0] bs, eb;
        logic ib, es;
        repeat (40)
        begin
            r = rand32();
            bs = boot_start(r[1:0]);
            @(posedge clk);
            fuses <= r[1:0];
            pc <= r[2] ? r[15:3] : bs - 13'h0001 + 13'(r[3]);
            idx <= 5'(1 + r[20:16] % 25);
            gie <= r[21];
            alock <= r[22];
            block_bit <= r[23];
            brf <= r[24];
            tick(3);
            eb = vsel ? bs : 13'h0000;
            ib = pc >= bs;
            es = vsel ? alock & ~ib : block_bit & ib;
            chk("vector base", eb, base);
            chk("vector addr", eb + {7'h00, idx, 1'b0}, vaddr);
            chk("reset addr", brf ? bs : 13'h0000, raddr);
            chk("lock suppress", 13'(es), 13'(supp));
            chk("irq allowed", 13'(gie & ~es), 13'(allow));
        end
    endtask

    // ========================================
    // Timeout, far above the expected few hundred cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fails++;
            conclude();
        end
    end

    // ========================================
    // Main sequence
    initial
    begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        bus_rd(CTRL_ADDR, 8'h00, "ctrl after reset");
        bus_wr(CTRL_ADDR, 8'hfe);
        bus_rd(CTRL_ADDR, 8'h00, "ctrl unarmed write");
        bus_wr(8'h36, 8'h01);
        bus_rd(8'h36, 8'h00, "unmapped read");
        chk("no arm from unmapped", 13'h0000, 13'(blk));
        sweep(1'b0);
        // Locks off so that only the unlock sequence gates interrupts
        @(posedge clk);
        gie <= 1'b1;
        pc <= 13'h0000;
        alock <= 1'b0;
        block_bit <= 1'b0;
        bus_wr(CTRL_ADDR, 8'h01);
        bus_wr(CTRL_ADDR, 8'h02);
        bus_rd(CTRL_ADDR, 8'h02, "ctrl after change");
        tick(4);
        chk("block until instr end", 13'h0001, 13'(blk));
        chk("allowed while blocked", 13'h0000, 13'(allow));
        end_instr();
        tick(1);
        chk("block released", 13'h0000, 13'(blk));
        chk("allowed after release", 13'h0001, 13'(allow));
        bus_wr(CTRL_ADDR, 8'h01);
        #1;
        for (int i = 0; i < UNLOCK_CYCLES; i++)
        begin
            chk("block in window", 13'h0001, 13'(blk));
            @(posedge clk);
            #1;
        end
        chk("block after lapse", 13'h0000, 13'(blk));
        bus_wr(CTRL_ADDR, 8'h00);
        bus_rd(CTRL_ADDR, 8'h02, "ctrl late write");
        bus_wr(CTRL_ADDR, 8'h01);
        bus_rd(CTRL_ADDR, 8'h03, "ctrl armed");
        // Rearm in the last window cycle; its select bit is ignored
        bus_wr(CTRL_ADDR, 8'h01);
        bus_rd(CTRL_ADDR, 8'h03, "ctrl rearmed");
        tick(4);
        chk("block after rearm lapse", 13'h0000, 13'(blk));
        sweep(1'b1);
        conclude();
    end
endmodule
`default_nettype wire
